// ==== verilog/sppa_top.sv ====
`timescale 1ns/1ps

// Overview of operation
// - Remember flip origin, answer main or blitter.
// - Upper key bounds matter only when keying.
// - YUV key needs all enabled channels in range.
// - RGB key compares low value, masked equality.
// - Upper bound bytes: red 23:16, green, blue.
// - Tiled offset used only for tiled surfaces.
// - Tiled offset takes effect at next vsync.
// - Offset holds line 27:16, pixel 11:0.
// - Rotation makes offset the lower right corner.
// - Alpha enable scales every channel before blender.
// - Alpha FF opaque, zero transparent, linear between.
// - Live register shows current surface base.
// - Contrast and brightness precede conversion, always applied.
// - Color adjustment registers take effect immediately.
// - Y multiplied by 3.6 contrast factor.
// - Signed brightness added after contrast multiply.
// - Gamma maps 8-bit to 10-bit, points padded with two low zero bits.
// - Gamma end points fixed at 0, 1023.
// - Interpolate between bracketing adjacent breakpoints.
// - Breakpoints hold red, green, blue bytes.
// - Double-buffered values load after trigger and vblank.
module sppa_top (
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  input  wire sppa_pkg::sppa_reg_req_type  req_i,
  output logic [31:0]                      reg_rdata_o,
  input  wire logic                        surf_wr_i,
  input  wire logic [19:0]                 surf_base_i,
  input  wire logic                        flip_src_i,
  input  wire logic                        vblank_i,
  input  wire logic                        vsync_i,
  input  wire logic                        key_en_i,
  input  wire logic [23:0]                 key_lower_i,
  input  wire logic [2:0]                  key_chan_en_i,
  input  wire logic                        tiled_i,
  input  wire logic                        rotate_i,
  input  wire logic [2:0][23:0]            gamma_upper_i,
  input  wire sppa_pkg::sppa_pix_in_type   pix_i,
  output sppa_pkg::sppa_pix_out_type       pix_o,
  output logic                             flip_done_main_o,
  output logic                             flip_done_blit_o,
  output logic [11:0]                      pan_x_o,
  output logic [11:0]                      pan_y_o,
  output logic                             pan_corner_o
);

  // ****************************************************************
  // Gamma curve helper
  // ****************************************************************

  // Breakpoints sit at inputs 8,16,32,64,128,192 so every segment but the
  // last spans a power of two; the division becomes a shift. The last
  // segment is treated as 64 wide and input 255 is forced to the top.
  function automatic logic [9:0] gamma_map(input logic [7:0]      x,
                                           input logic [5:0][7:0] pts);
    logic [7:0][9:0]    ys;
    logic [2:0]         seg;
    logic [7:0]         x0;
    logic [2:0]         sh;
    logic signed [11:0] d;
    logic signed [19:0] p;
    logic signed [19:0] q;
    ys[0] = 10'h000;
    for (int i = 0; i < 6; i++) begin
      ys[i+1] = {pts[i], 2'b00};
    end
    ys[7] = sppa_pkg::GAMMA_TOP;
    if (x < 8'h08) begin
      seg = 3'd0; x0 = 8'h00; sh = 3'd3;
    end else if (x < 8'h10) begin
      seg = 3'd1; x0 = 8'h08; sh = 3'd3;
    end else if (x < 8'h20) begin
      seg = 3'd2; x0 = 8'h10; sh = 3'd4;
    end else if (x < 8'h40) begin
      seg = 3'd3; x0 = 8'h20; sh = 3'd5;
    end else if (x < 8'h80) begin
      seg = 3'd4; x0 = 8'h40; sh = 3'd6;
    end else if (x < 8'hc0) begin
      seg = 3'd5; x0 = 8'h80; sh = 3'd6;
    end else begin
      seg = 3'd6; x0 = 8'hc0; sh = 3'd6;
    end
    // Signed slope so descending curves interpolate correctly.
    d = $signed({2'b00, ys[seg + 3'd1]}) - $signed({2'b00, ys[seg]});
    p = 20'(d) * 20'($signed({1'b0, 7'(x - x0)}));
    q = $signed({10'h000, ys[seg]}) + (p >>> sh);
    if (x == 8'hff) begin
      return sppa_pkg::GAMMA_TOP;
    end
    return q[9:0];
  endfunction

  // ****************************************************************
  // State and next-state
  // ****************************************************************
  sppa_pkg::sppa_state_type st;
  sppa_pkg::sppa_state_type next_st;

  logic             vbl_rise;
  logic             vs_rise;
  logic [16:0]      y_prod;
  logic [12:0]      y_sum;
  logic [7:0]       y_adj;
  logic [2:0]       in_range;
  logic             key_hit;
  logic [5:0][7:0]  pts;
  logic [18:0]      a_prod;

  // All state moves through one next-state process; the datapath is a
  // three-stage pipe: key and Y adjust, gamma, then constant alpha.
  always_comb begin
    next_st = st;
    vbl_rise = vblank_i & ~st.vbl_q;
    vs_rise = vsync_i & ~st.vs_q;
    next_st.vbl_q = vblank_i;
    next_st.vs_q = vsync_i;
    next_st.flip_main = 1'b0;
    next_st.flip_blit = 1'b0;
    next_st.rdata = 32'h0000_0000;

    // Register writes; colour adjust and gamma land at once.
    if (req_i.wr) begin
      case (req_i.addr)
        sppa_pkg::OFF_KEY_UPPER: begin
          next_st.key_upper_pend = req_i.wdata[23:0];
        end
        sppa_pkg::OFF_TILED_PAN: begin
          next_st.pan_pend = {req_i.wdata[27:16], req_i.wdata[11:0]};
        end
        sppa_pkg::OFF_FIXED_ALPHA: begin
          next_st.alpha_pend = {req_i.wdata[sppa_pkg::ALPHA_EN_BIT], req_i.wdata[7:0]};
        end
        sppa_pkg::OFF_CONTRAST_BRIGHT: begin
          next_st.contrast = req_i.wdata[sppa_pkg::CONTRAST_LSB +: 9];
          next_st.bright = req_i.wdata[sppa_pkg::BRIGHT_LSB +: 8];
        end
        sppa_pkg::OFF_GAMMA_POINT_0: begin
          next_st.gam[0] = req_i.wdata[23:0];
        end
        sppa_pkg::OFF_GAMMA_POINT_1: begin
          next_st.gam[1] = req_i.wdata[23:0];
        end
        sppa_pkg::OFF_GAMMA_POINT_2: begin
          next_st.gam[2] = req_i.wdata[23:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads answer one cycle later; unmapped offsets read zero.
    if (req_i.rd) begin
      case (req_i.addr)
        sppa_pkg::OFF_KEY_UPPER: begin
          next_st.rdata = {8'h00, st.key_upper_pend};
        end
        sppa_pkg::OFF_TILED_PAN: begin
          next_st.rdata = {4'h0, st.pan_pend[23:12], 4'h0, st.pan_pend[11:0]};
        end
        sppa_pkg::OFF_FIXED_ALPHA: begin
          next_st.rdata = {st.alpha_pend[8], 23'h000000, st.alpha_pend[7:0]};
        end
        sppa_pkg::OFF_CURRENT_SURF: begin
          next_st.rdata = {st.live_surf, 8'h00, st.flip_src, 3'h0};
        end
        sppa_pkg::OFF_CONTRAST_BRIGHT: begin
          next_st.rdata = {5'h00, st.contrast, 10'h000, st.bright};
        end
        sppa_pkg::OFF_GAMMA_POINT_0: begin
          next_st.rdata = {8'h00, st.gam[0]};
        end
        sppa_pkg::OFF_GAMMA_POINT_1: begin
          next_st.rdata = {8'h00, st.gam[1]};
        end
        sppa_pkg::OFF_GAMMA_POINT_2: begin
          next_st.rdata = {8'h00, st.gam[2]};
        end
        default: begin
        end
      endcase
    end

    // The tiled offset follows vsync alone, not the flip trigger.
    if (vs_rise) begin
      next_st.pan_act = st.pan_pend;
    end
    // Linear surfaces see a zero offset; rotation marks corner mode on tiled surfaces only.
    next_st.pan_y = tiled_i ? st.pan_act[23:12] : 12'h000;
    next_st.pan_x = tiled_i ? st.pan_act[11:0] : 12'h000;
    next_st.pan_corner = tiled_i & rotate_i;

    // A surface write arms the flip; a write in the vblank cycle re-arms
    // so the new address is not lost.
    if (surf_wr_i) begin
      next_st.surf_pend = surf_base_i;
      next_st.src_pend = flip_src_i;
    end
    next_st.flip_armed = surf_wr_i | (st.flip_armed & ~vbl_rise);
    if (vbl_rise && st.flip_armed) begin
      next_st.live_surf = st.surf_pend;
      next_st.flip_src = st.src_pend;
      next_st.key_upper = st.key_upper_pend;
      next_st.alpha = st.alpha_pend;
      next_st.flip_main = (st.src_pend == sppa_pkg::FLIP_SRC_MAIN);
      next_st.flip_blit = (st.src_pend == sppa_pkg::FLIP_SRC_BLIT);
    end

    // Stage 1: colour key on the raw pixel.
    for (int c = 0; c < 3; c++) begin
      in_range[c] = ~key_chan_en_i[c] |
                    ((pix_i.data[c*8 +: 8] >= key_lower_i[c*8 +: 8]) &&
                     (pix_i.data[c*8 +: 8] <= st.key_upper[c*8 +: 8]));
    end
    if (pix_i.yuv) begin
      key_hit = &in_range;
    end else begin
      key_hit = ((pix_i.data ^ key_lower_i) &
                 {{8{key_chan_en_i[2]}}, {8{key_chan_en_i[1]}}, {8{key_chan_en_i[0]}}})
                == 24'h000000;
    end
    next_st.s1_match = key_en_i & key_hit;
    next_st.s1_valid = pix_i.valid;

    // Stage 1: Y adjust, always applied ahead of any conversion.
    y_prod = 17'(pix_i.data[15:8]) * 17'(st.contrast);
    y_sum = 13'({2'b00, y_prod[16:sppa_pkg::CONTRAST_FRAC]}) +
            {{5{st.bright[7]}}, st.bright};
    if (y_sum[12]) begin
      y_adj = 8'h00;
    end else if (y_sum[11:8] != 4'h0) begin
      y_adj = 8'hff;
    end else begin
      y_adj = y_sum[7:0];
    end
    next_st.s1_pix = {pix_i.data[23:16], y_adj, pix_i.data[7:0]};

    // Stage 2: per-channel piecewise-linear gamma.
    next_st.s2_valid = st.s1_valid;
    next_st.s2_match = st.s1_match;
    pts = '0;
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 3; i++) begin
        pts[i] = st.gam[i][c*8 +: 8];
        pts[i+3] = gamma_upper_i[i][c*8 +: 8];
      end
      next_st.s2_g[c] = gamma_map(st.s1_pix[c*8 +: 8], pts);
    end

    // Stage 3: constant alpha; multiplying by alpha+1 keeps FF exact.
    next_st.out.valid = st.s2_valid;
    next_st.out.key_match = st.s2_match;
    a_prod = '0;
    for (int c = 0; c < 3; c++) begin
      a_prod = 19'(st.s2_g[c]) * 19'({1'b0, st.alpha[7:0]}) + 19'(st.s2_g[c]);
      if (!st.alpha[8]) begin
        next_st.out.data[c*10 +: 10] = st.s2_g[c];
      end else if (st.alpha[7:0] == 8'h00) begin
        next_st.out.data[c*10 +: 10] = 10'h000;
      end else begin
        next_st.out.data[c*10 +: 10] = a_prod[17:8];
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Reset loads the documented defaults; everything else clears.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
      st.key_upper_pend <= sppa_pkg::RST_KEY_UPPER[23:0];
      st.key_upper <= sppa_pkg::RST_KEY_UPPER[23:0];
      st.pan_pend <= {sppa_pkg::RST_TILED_PAN[27:16], sppa_pkg::RST_TILED_PAN[11:0]};
      st.pan_act <= {sppa_pkg::RST_TILED_PAN[27:16], sppa_pkg::RST_TILED_PAN[11:0]};
      st.alpha_pend <= {sppa_pkg::RST_FIXED_ALPHA[31], sppa_pkg::RST_FIXED_ALPHA[7:0]};
      st.alpha <= {sppa_pkg::RST_FIXED_ALPHA[31], sppa_pkg::RST_FIXED_ALPHA[7:0]};
      st.contrast <= sppa_pkg::RST_CONTRAST_BRIGHT[26:18];
      st.bright <= sppa_pkg::RST_CONTRAST_BRIGHT[7:0];
      st.gam[0] <= sppa_pkg::RST_GAMMA_POINT_0[23:0];
      st.gam[1] <= sppa_pkg::RST_GAMMA_POINT_1[23:0];
      st.gam[2] <= sppa_pkg::RST_GAMMA_POINT_2[23:0];
    end else begin
      st <= next_st;
    end
  end

  // Every output is a plain flip-flop of the state.
  assign reg_rdata_o = st.rdata;
  assign pix_o = st.out;
  assign flip_done_main_o = st.flip_main;
  assign flip_done_blit_o = st.flip_blit;
  assign pan_x_o = st.pan_x;
  assign pan_y_o = st.pan_y;
  assign pan_corner_o = st.pan_corner;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_flip_to_main: assert property (
    vbl_rise && st.flip_armed && !st.src_pend |=> flip_done_main_o && !flip_done_blit_o)
    else $error("flip done not sent to main streamer");
  a_flip_to_blit: assert property (
    vbl_rise && st.flip_armed && st.src_pend |=> flip_done_blit_o && !flip_done_main_o)
    else $error("flip done not sent to blitter streamer");
  a_key_off_nomatch: assert property (
    pix_i.valid && !key_en_i |-> ##3 pix_o.valid && !pix_o.key_match)
    else $error("key match without keying enabled");
  a_rgb_key_equal: assert property (
    pix_i.valid && !pix_i.yuv && key_en_i && key_chan_en_i == 3'h7 &&
    pix_i.data == key_lower_i |=> st.s1_match)
    else $error("rgb pixel equal to key did not match");
  a_yuv_out_range: assert property (
    pix_i.valid && pix_i.yuv && key_chan_en_i[1] &&
    pix_i.data[15:8] < key_lower_i[15:8] |=> !st.s1_match)
    else $error("yuv pixel outside range matched");
  a_pan_vsync_only: assert property (
    !vs_rise |=> $stable(st.pan_act))
    else $error("tiled offset changed without vsync");
  a_pan_linear_zero: assert property (
    !tiled_i |=> pan_x_o == 12'h000 && pan_y_o == 12'h000)
    else $error("pan offset shown for linear surface");
  a_clrc_immediate: assert property (
    req_i.wr && req_i.addr == sppa_pkg::OFF_CONTRAST_BRIGHT
    |=> st.contrast == $past(req_i.wdata[26:18]) && st.bright == $past(req_i.wdata[7:0]))
    else $error("colour adjust did not load at once");
  a_gamma_top_fixed: assert property (
    st.s1_valid && st.s1_pix[23:16] == 8'hff |=> st.s2_g[2] == sppa_pkg::GAMMA_TOP)
    else $error("gamma top end point not 1023");
  a_alpha_bypass: assert property (
    st.s2_valid && !st.alpha[8] |=> pix_o.data == $past({st.s2_g[2], st.s2_g[1], st.s2_g[0]}))
    else $error("pixel altered with alpha disabled");
  a_live_surf_read: assert property (
    req_i.rd && req_i.addr == sppa_pkg::OFF_CURRENT_SURF |=> reg_rdata_o[31:12] == $past(st.live_surf))
    else $error("live surface read wrong");

  // Pixel path bottom gamma end point, unity adjust and a zero alpha value.
  a_gamma_bottom_fixed: assert property (
    st.s1_valid && st.s1_pix[23:16] == 8'h00 |=> st.s2_g[2] == 10'h000)
    else $error("gamma bottom end point not zero");
  a_alpha_zero_clear: assert property (
    st.s2_valid && st.alpha == 9'h100 |=> pix_o.data == 30'h0000_0000)
    else $error("zero alpha did not clear the pixel");
  a_bright_zero_keep: assert property (
    pix_i.valid && st.contrast == 9'h040 && st.bright == 8'h00
    |=> st.s1_pix[15:8] == $past(pix_i.data[15:8]))
    else $error("unity contrast and zero brightness changed Y");

  // Offset and surface loads at their own events, and the rotation corner flag.
  a_pan_load_vsync: assert property (
    vs_rise |=> st.pan_act == $past(st.pan_pend))
    else $error("tiled offset not loaded at vsync");
  a_pan_corner_rot: assert property (
    tiled_i && rotate_i |=> pan_corner_o)
    else $error("rotation did not select corner mode");
  a_flip_live_load: assert property (
    vbl_rise && st.flip_armed
    |=> st.live_surf == $past(st.surf_pend) && st.flip_src == $past(st.src_pend))
    else $error("live surface not loaded at flip");

  c_flip_blit:  cover property (surf_wr_i && flip_src_i ##[1:50] flip_done_blit_o);
  c_key_match:  cover property (pix_o.valid && pix_o.key_match);
  c_pan_update: cover property (req_i.wr && req_i.addr == sppa_pkg::OFF_TILED_PAN ##[1:100] vs_rise);
  c_alpha_mid:  cover property (pix_o.valid && st.alpha[8] && st.alpha[7:0] == 8'h80);

endmodule

// ==== verilog/sppa_pkg.sv ====
package sppa_pkg;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam int          ADDR_W             = 20;
  localparam logic [19:0] OFF_KEY_UPPER      = 20'h721a0;
  localparam logic [19:0] OFF_TILED_PAN      = 20'h721a4;
  localparam logic [19:0] OFF_FIXED_ALPHA    = 20'h721a8;
  localparam logic [19:0] OFF_CURRENT_SURF   = 20'h721ac;
  localparam logic [19:0] OFF_CONTRAST_BRIGHT = 20'h721d0;
  localparam logic [19:0] OFF_GAMMA_POINT_2  = 20'h721ec;
  localparam logic [19:0] OFF_GAMMA_POINT_1  = 20'h721f0;
  localparam logic [19:0] OFF_GAMMA_POINT_0  = 20'h721f4;

  localparam logic [31:0] RST_KEY_UPPER      = 32'h0000_0000;
  localparam logic [31:0] RST_TILED_PAN      = 32'h0000_0000;
  localparam logic [31:0] RST_FIXED_ALPHA    = 32'h0000_0000;
  localparam logic [31:0] RST_CONTRAST_BRIGHT = 32'h0010_0000;
  localparam logic [31:0] RST_GAMMA_POINT_0  = 32'h0008_0808;
  localparam logic [31:0] RST_GAMMA_POINT_1  = 32'h0010_1010;
  localparam logic [31:0] RST_GAMMA_POINT_2  = 32'h0020_2020;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ALPHA_EN_BIT   = 31;
  localparam int PAN_Y_LSB      = 16;
  localparam int PAN_X_LSB      = 0;
  localparam int CONTRAST_LSB   = 18;
  localparam int BRIGHT_LSB     = 0;
  localparam int SURF_LSB       = 12;
  localparam int FLIP_SRC_BIT   = 3;
  localparam int CONTRAST_FRAC  = 6;
  localparam logic       FLIP_SRC_MAIN = 1'b0;
  localparam logic       FLIP_SRC_BLIT = 1'b1;
  localparam logic [9:0] GAMMA_TOP     = 10'h3ff;

  // ****************************************************************
  // Carriers and state
  // ****************************************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } sppa_reg_req_type;

  typedef struct packed {
    logic        valid;
    logic        yuv;
    logic [23:0] data;
  } sppa_pix_in_type;

  typedef struct packed {
    logic        valid;
    logic        key_match;
    logic [29:0] data;
  } sppa_pix_out_type;

  typedef struct packed {
    logic [23:0]      key_upper_pend;
    logic [23:0]      key_upper;
    logic [8:0]       alpha_pend;
    logic [8:0]       alpha;
    logic [23:0]      pan_pend;
    logic [23:0]      pan_act;
    logic [8:0]       contrast;
    logic [7:0]       bright;
    logic [2:0][23:0] gam;
    logic [19:0]      surf_pend;
    logic             src_pend;
    logic             flip_armed;
    logic [19:0]      live_surf;
    logic             flip_src;
    logic             vbl_q;
    logic             vs_q;
    logic [31:0]      rdata;
    logic             flip_main;
    logic             flip_blit;
    logic [11:0]      pan_x;
    logic [11:0]      pan_y;
    logic             pan_corner;
    logic             s1_valid;
    logic             s1_match;
    logic [23:0]      s1_pix;
    logic             s2_valid;
    logic             s2_match;
    logic [2:0][9:0]  s2_g;
    sppa_pix_out_type out;
  } sppa_state_type;

endpackage

// ==== verif/sppa_partner.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Command streamer flips and pipe blender capture
// ****************************************************************
module sppa_partner (
  input  wire logic                       clk_i,
  input  wire sppa_pkg::sppa_pix_out_type pix_i,
  output logic                            surf_wr_o,
  output logic [19:0]                     surf_base_o,
  output logic                            flip_src_o,
  output sppa_pkg::sppa_pix_out_type      last_pix_o
);
  // The lines start idle so that no flip is requested during reset.
  initial begin
    surf_wr_o   = 1'b0;
    surf_base_o = 20'h0;
    flip_src_o  = 1'b0;
  end

  // One flip request; afterwards the lines show the inverse, so stale data is never reused.
  task automatic do_flip(input logic src, input logic [19:0] base);
    @(posedge clk_i);
    surf_wr_o   <= 1'b1;
    surf_base_o <= base;
    flip_src_o  <= src;
    @(posedge clk_i);
    surf_wr_o   <= 1'b0;
    surf_base_o <= ~base;
    flip_src_o  <= ~src;
  endtask

  // The blender takes every valid pixel, since it cannot stall the sprite path.
  always_ff @(posedge clk_i) begin
    if (pix_i.valid) last_pix_o <= pix_i;
  end
endmodule

// ==== verif/test_sppa_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

// ****************************************************************
// Register, flip, pan and pixel path checks
// ****************************************************************
module test_sppa_top;
  logic                       clk_i, resetn_i, surf_wr, flip_src, vblank_i, vsync_i;
  logic                       key_en_i, tiled_i, rotate_i, done_main, done_blit, pan_corner_o;
  logic [19:0]                surf_base;
  logic [31:0]                reg_rdata_o;
  logic [23:0]                key_lower_i;
  logic [2:0]                 key_chan_en_i;
  logic [2:0][23:0]           gamma_upper_i;
  logic [11:0]                pan_x_o, pan_y_o;
  sppa_pkg::sppa_reg_req_type req_i;
  sppa_pkg::sppa_pix_in_type  pix_i;
  sppa_pkg::sppa_pix_out_type pix_o, last_pix;
  int                         errors = 0;
  int                         n_checks = 0;
  localparam logic [19:0] ADR [8] = '{sppa_pkg::OFF_KEY_UPPER, sppa_pkg::OFF_TILED_PAN,
    sppa_pkg::OFF_FIXED_ALPHA, sppa_pkg::OFF_CURRENT_SURF, sppa_pkg::OFF_CONTRAST_BRIGHT,
    sppa_pkg::OFF_GAMMA_POINT_2, sppa_pkg::OFF_GAMMA_POINT_1, sppa_pkg::OFF_GAMMA_POINT_0};
  localparam logic [31:0] RST [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0010_0000,
    32'h0020_2020, 32'h0010_1010, 32'h0008_0808};

  sppa_top u_sppa_top (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
    .reg_rdata_o(reg_rdata_o), .surf_wr_i(surf_wr), .surf_base_i(surf_base),
    .flip_src_i(flip_src), .vblank_i(vblank_i), .vsync_i(vsync_i), .key_en_i(key_en_i),
    .key_lower_i(key_lower_i), .key_chan_en_i(key_chan_en_i), .tiled_i(tiled_i),
    .rotate_i(rotate_i), .gamma_upper_i(gamma_upper_i), .pix_i(pix_i), .pix_o(pix_o),
    .flip_done_main_o(done_main), .flip_done_blit_o(done_blit), .pan_x_o(pan_x_o),
    .pan_y_o(pan_y_o), .pan_corner_o(pan_corner_o));
  sppa_partner u_sppa_partner (.clk_i(clk_i), .pix_i(pix_o), .surf_wr_o(surf_wr),
    .surf_base_o(surf_base), .flip_src_o(flip_src), .last_pix_o(last_pix));

  // Expected curve for the identity breakpoints; the top segment is 64 wide.
  function automatic logic [9:0] gm(input int x);
    if (x == 255) return 10'h3ff;
    if (x < 192) return 10'(x * 4);
    return 10'(768 + ((255 * (x - 192)) >> 6));
  endfunction
  function automatic logic [29:0] idp(input logic [23:0] d);
    return {gm(d[23:16]), gm(d[15:8]), gm(d[7:0])};
  endfunction
  // Fixed alpha scaling; a value of 255 leaves the pixel unchanged.
  function automatic logic [29:0] ap(input logic [29:0] v, input int a);
    return {10'((v[29:20] * (a + 1)) >> 8), 10'((v[19:10] * (a + 1)) >> 8),
      10'((v[9:0] * (a + 1)) >> 8)};
  endfunction

  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask
  // Read data is registered and stands for the cycle after the strobe only.
  task automatic chk_reg(input logic [19:0] a, input logic [31:0] e);
    @(posedge clk_i);
    req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    #1 `CHK(reg_rdata_o, e)
  endtask
  task automatic pix_chk(input logic y, input logic [23:0] d, input logic [29:0] e,
                         input logic m);
    @(posedge clk_i);
    pix_i <= '{valid: 1'b1, yuv: y, data: d};
    @(posedge clk_i);
    pix_i.valid <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 `CHK(pix_o.valid, 1'b1)
    @(posedge clk_i);
    #1 `CHK(last_pix.data, e)
    `CHK(last_pix.key_match, m)
  endtask
  // A bounded wait for the done pulse of the right streamer; the other must stay low.
  task automatic flip(input logic src, input logic [19:0] base);
    int   hits = 0;
    logic wrong = 1'b0;
    u_sppa_partner.do_flip(src, base);
    @(posedge clk_i);
    vblank_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      #1 if ((src ? done_blit : done_main) === 1'b1) hits++;
      if ((src ? done_main : done_blit) !== 1'b0) wrong = 1'b1;
    end
    @(posedge clk_i);
    vblank_i <= 1'b0;
    `CHK(hits, 1)
    `CHK(wrong, 1'b0)
    if (hits == 0) report_and_stop();
    chk_reg(sppa_pkg::OFF_CURRENT_SURF, {base, 8'h0, src, 3'b0});
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // A hang is cut short and counted as a mismatch.
  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end

  initial begin
    {resetn_i, vblank_i, vsync_i, key_en_i, tiled_i, rotate_i} = '0;
    req_i = '0;
    pix_i = '0;
    key_lower_i = 24'h101010;
    key_chan_en_i = 3'h7;
    gamma_upper_i = {24'hc0c0c0, 24'h808080, 24'h404040};
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 8; i++) chk_reg(ADR[i], RST[i]);
    chk_reg(20'h721b0, 32'h0);
    wr_reg(sppa_pkg::OFF_CURRENT_SURF, 32'hffff_ffff);
    chk_reg(sppa_pkg::OFF_CURRENT_SURF, 32'h0);
    wr_reg(sppa_pkg::OFF_CONTRAST_BRIGHT, 32'h0100_0000);
    pix_chk(1'b0, 24'h0080ff, {10'h0, 10'h200, 10'h3ff}, 1'b0);
    wr_reg(sppa_pkg::OFF_CONTRAST_BRIGHT, 32'h0200_00f6);
    chk_reg(sppa_pkg::OFF_CONTRAST_BRIGHT, 32'h0200_00f6);
    pix_chk(1'b1, 24'h103210, {10'd64, 10'd360, 10'd64}, 1'b0);
    pix_chk(1'b1, 24'h00c800, {10'd0, 10'h3ff, 10'd0}, 1'b0);
    wr_reg(sppa_pkg::OFF_CONTRAST_BRIGHT, 32'h0100_0080);
    pix_chk(1'b1, 24'h004000, 30'h0, 1'b0);
    wr_reg(sppa_pkg::OFF_CONTRAST_BRIGHT, 32'h0100_0000);
    wr_reg(sppa_pkg::OFF_GAMMA_POINT_0, 32'h0008_0810);
    pix_chk(1'b0, 24'h000404, {10'd0, 10'd16, 10'd32}, 1'b0);
    wr_reg(sppa_pkg::OFF_GAMMA_POINT_0, sppa_pkg::RST_GAMMA_POINT_0);
    wr_reg(sppa_pkg::OFF_KEY_UPPER, 32'h0050_3020);
    chk_reg(sppa_pkg::OFF_KEY_UPPER, 32'h0050_3020);
    wr_reg(sppa_pkg::OFF_FIXED_ALPHA, 32'h8000_0080);
    chk_reg(sppa_pkg::OFF_FIXED_ALPHA, 32'h8000_0080);
    @(posedge clk_i);
    key_en_i <= 1'b1;
    pix_chk(1'b1, 24'h403020, idp(24'h403020), 1'b0);
    flip(1'b1, 20'habcde);
    pix_chk(1'b1, 24'h403020, ap(idp(24'h403020), 128), 1'b1);
    pix_chk(1'b1, 24'h402021, ap(idp(24'h402021), 128), 1'b0);
    pix_chk(1'b0, 24'h101010, ap(idp(24'h101010), 128), 1'b1);
    pix_chk(1'b0, 24'h201010, ap(idp(24'h201010), 128), 1'b0);
    @(posedge clk_i);
    key_chan_en_i <= 3'b110;
    pix_chk(1'b1, 24'h402021, ap(idp(24'h402021), 128), 1'b1);
    pix_chk(1'b0, 24'h101011, ap(idp(24'h101011), 128), 1'b1);
    @(posedge clk_i);
    key_en_i <= 1'b0;
    pix_chk(1'b1, 24'h403020, ap(idp(24'h403020), 128), 1'b0);
    wr_reg(sppa_pkg::OFF_FIXED_ALPHA, 32'h8000_0000);
    flip(1'b0, 20'h12345);
    pix_chk(1'b0, 24'h6400ff, 30'h0, 1'b0);
    wr_reg(sppa_pkg::OFF_FIXED_ALPHA, 32'h0000_0010);
    flip(1'b0, 20'h00001);
    pix_chk(1'b0, 24'h6400ff, idp(24'h6400ff), 1'b0);
    wr_reg(sppa_pkg::OFF_TILED_PAN, 32'h0123_0456);
    chk_reg(sppa_pkg::OFF_TILED_PAN, 32'h0123_0456);
    @(posedge clk_i);
    tiled_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 `CHK(pan_x_o, 12'h0)
    @(posedge clk_i);
    vsync_i <= 1'b1;
    @(posedge clk_i);
    vsync_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 `CHK({pan_y_o, pan_x_o, pan_corner_o}, {12'h123, 12'h456, 1'b0})
    @(posedge clk_i);
    rotate_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 `CHK(pan_corner_o, 1'b1)
    @(posedge clk_i);
    tiled_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 `CHK({pan_y_o, pan_x_o, pan_corner_o}, 25'h0)
    report_and_stop();
  end
endmodule
